// *** acts_channel_cfg.v ***
// per-channel trigger mode, early interrupt and sign selection with ahb-lite registers
`timescale 1ns/100ps
`include "acts_regs.vh"

module acts_channel_cfg #(
  parameter NCH = 21,
  parameter RW  = 12
) (
  // clock and reset
  input  wire                hclk,
  input  wire                hresetn,
  // ahb-lite slave
  input  wire                hsel,
  input  wire [11:0]         haddr,
  input  wire [1:0]          htrans,
  input  wire                hwrite,
  input  wire [2:0]          hsize,
  input  wire                hready,
  input  wire [31:0]         hwdata,
  output reg  [31:0]         hrdata,
  output reg                 hreadyout,
  output reg                 hresp,
  // converter core side (same clock)
  input  wire [NCH-1:0]      chan_trigger,
  input  wire [NCH-1:0]      conv_busy,
  input  wire [NCH-1:0]      early_event,
  input  wire                result_valid,
  input  wire [4:0]          result_chan,
  input  wire [RW-1:0]       result_raw,
  input  wire                buf_read,
  input  wire [4:0]          buf_read_chan,
  // outputs
  output reg  [NCH-1:0]      conv_start_ff,
  output reg                 fmt_valid_ff,
  output reg  [4:0]          fmt_chan_ff,
  output reg  [15:0]         fmt_data_ff,
  output reg  [NCH-1:0]      ready_ff,
  output reg                 irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_DATA = 1'b1;

  reg [NCH-1:0]            lvl_sel_ff;
  reg [NCH-1:0]            eie_ff;
  reg [NCH-1:0]            eis_ff;
  reg [NCH-1:0]            sign_ff;
  reg [NCH-1:0]            trig_d_ff;
  reg [`ACTS_IRQ_W-1:0]    ist_ff;
  reg [`ACTS_IRQ_W-1:0]    ien_ff;
  reg                      st_ff;
  reg                      wr_ff;
  reg [11:0]               addr_ff;
  reg [NCH-1:0]            nxt_eis;
  reg [NCH-1:0]            nxt_ready;
  reg [NCH-1:0]            nxt_start;
  reg [NCH-1:0]            nxt_lvl;
  reg [NCH-1:0]            nxt_eie;
  reg [NCH-1:0]            nxt_sign;
  reg [`ACTS_IRQ_W-1:0]    nxt_ist;
  reg [`ACTS_IRQ_W-1:0]    nxt_ien;
  reg [15:0]               rd_val;
  reg                      early_any;
  integer                  i;

  // spread 8 sign bits onto the even positions of a 16-bit word
  function [15:0] spread8;
    input [7:0] v;
    integer k;
    begin
      spread8 = 16'h0000;
      for (k = 0; k < 8; k = k + 1)
        spread8[2*k] = v[k];
    end
  endfunction

  // gather even positions of a written word back into 8 sign bits
  function [7:0] gather8;
    input [15:0] v;
    integer k;
    begin
      gather8 = 8'h00;
      for (k = 0; k < 8; k = k + 1)
        gather8[k] = v[2*k];
    end
  endfunction

  // one-hot decode of a channel number, used for results and buffer reads
  function [NCH-1:0] chan_dec;
    input [4:0] c;
    integer k;
    begin
      chan_dec = {NCH{1'b0}};
      for (k = 0; k < NCH; k = k + 1)
        if (c == k[4:0])
          chan_dec[k] = 1'b1;
    end
  endfunction

  wire addr_take = hsel & hready & htrans[1];
  wire wr_now    = (st_ff == ST_DATA) & wr_ff;
  wire [15:0] wd = hwdata[15:0];
  // a read is decoded in its address phase; hsize is ignored, every access is a word
  wire        rd_take  = addr_take & ~hwrite;
  wire [11:0] rd_addr  = {haddr[11:2], 2'b00};
  wire [7:0]  wd_even  = gather8(wd);
  // channel numbers above the last input format as unsigned
  wire        res_sign = (result_chan < NCH) ? sign_ff[result_chan] : 1'b0;
  wire [NCH-1:0] buf_clr = buf_read ? chan_dec(buf_read_chan) : {NCH{1'b0}};
  wire [NCH-1:0] res_set = result_valid ? chan_dec(result_chan) : {NCH{1'b0}};

  // trigger qualification and flag updates
  always @*
  begin
    // edge mode: a rise that lands while the channel is busy is dropped, not queued
    nxt_start = {NCH{1'b0}};
    for (i = 0; i < NCH; i = i + 1)
    begin
      if (lvl_sel_ff[i])
        nxt_start[i] = chan_trigger[i] & ~conv_busy[i];
      else
        nxt_start[i] = chan_trigger[i] & ~trig_d_ff[i] & ~conv_busy[i];
    end
    // an early event in the same cycle as the buffer read wins over the clear
    nxt_eis = (eis_ff & ~buf_clr) | (early_event & eie_ff);
    if (wr_now && addr_ff == `ACTS_OFS_EIS_LO)
      nxt_eis[15:0] = nxt_eis[15:0] & wd | (early_event[15:0] & eie_ff[15:0]);
    if (wr_now && addr_ff == `ACTS_OFS_EIS_HI)
      nxt_eis[NCH-1:16] = nxt_eis[NCH-1:16] & wd[4:0]
                          | (early_event[NCH-1:16] & eie_ff[NCH-1:16]);
    nxt_ready = (ready_ff & ~buf_clr) | res_set;
    early_any = |(early_event & eie_ff);
    // a write-one clear and a new event in one cycle: the event wins
    nxt_ist = ist_ff;
    if (wr_now && addr_ff == `ACTS_OFS_IRQ_CLR)
      nxt_ist = ist_ff & ~wd[`ACTS_IRQ_W-1:0];
    nxt_ist[`ACTS_IRQ_EARLY] = nxt_ist[`ACTS_IRQ_EARLY] | early_any;
    nxt_ist[`ACTS_IRQ_READY] = nxt_ist[`ACTS_IRQ_READY] | result_valid;
  end

  // register write decode; the read mux below works on these next values
  always @*
  begin
    nxt_lvl  = lvl_sel_ff;
    nxt_eie  = eie_ff;
    nxt_sign = sign_ff;
    nxt_ien  = ien_ff;
    if (wr_now)
    begin
      // only even bits reach the sign register; odd and upper bits read back zero
      case (addr_ff)
        `ACTS_OFS_LVL_LO:  nxt_lvl[15:0]      = wd;
        `ACTS_OFS_LVL_HI:  nxt_lvl[NCH-1:16]  = wd[NCH-17:0];
        `ACTS_OFS_EIE_LO:  nxt_eie[15:0]      = wd;
        `ACTS_OFS_EIE_HI:  nxt_eie[NCH-1:16]  = wd[NCH-17:0];
        `ACTS_OFS_MOD0_LO: nxt_sign[7:0]      = wd_even;
        `ACTS_OFS_MOD0_HI: nxt_sign[15:8]     = wd_even;
        `ACTS_OFS_MOD1_LO: nxt_sign[NCH-1:16] = wd_even[NCH-17:0];
        `ACTS_OFS_IRQ_EN:  nxt_ien            = wd[`ACTS_IRQ_W-1:0];
        default:           nxt_ien            = ien_ff;
      endcase
    end
  end

  // read mux on the address-phase address, over the values registers take at that edge
  always @*
  begin
    case (rd_addr)
      `ACTS_OFS_LVL_LO:   rd_val = nxt_lvl[15:0];
      `ACTS_OFS_LVL_HI:   rd_val = {11'h000, nxt_lvl[NCH-1:16]};
      `ACTS_OFS_EIE_LO:   rd_val = nxt_eie[15:0];
      `ACTS_OFS_EIE_HI:   rd_val = {11'h000, nxt_eie[NCH-1:16]};
      `ACTS_OFS_EIS_LO:   rd_val = nxt_eis[15:0];
      `ACTS_OFS_EIS_HI:   rd_val = {11'h000, nxt_eis[NCH-1:16]};
      `ACTS_OFS_MOD0_LO:  rd_val = spread8(nxt_sign[7:0]);
      `ACTS_OFS_MOD0_HI:  rd_val = spread8(nxt_sign[15:8]);
      `ACTS_OFS_MOD1_LO:  rd_val = spread8({3'h0, nxt_sign[NCH-1:16]});
      `ACTS_OFS_IRQ_STAT: rd_val = {14'h0000, nxt_ist};
      `ACTS_OFS_IRQ_EN:   rd_val = {14'h0000, nxt_ien};
      `ACTS_OFS_RDY_LO:   rd_val = nxt_ready[15:0];
      `ACTS_OFS_RDY_HI:   rd_val = {11'h000, nxt_ready[NCH-1:16]};
      default:            rd_val = 16'h0000;
    endcase
  end

  // bus slave: zero wait states, always okay
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff     <= ST_IDLE;
      wr_ff     <= 1'b0;
      addr_ff   <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      case (st_ff)
        ST_IDLE:
        begin
          if (addr_take)
          begin
            st_ff   <= ST_DATA;
            wr_ff   <= hwrite;
            addr_ff <= {haddr[11:2], 2'b00};
          end
        end
        ST_DATA:
        begin
          if (addr_take)
          begin
            wr_ff   <= hwrite;
            addr_ff <= {haddr[11:2], 2'b00};
          end
          else
            st_ff <= ST_IDLE;
        end
        default:
          st_ff <= ST_IDLE;
      endcase
    end
  end

  // read data is registered at the address phase from the post-update register view,
  // so a read straight behind a write to the same register already returns new data
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd_take)
      hrdata <= {16'h0000, rd_val};
  end

  // configuration registers, loaded from the write decode above
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lvl_sel_ff <= {NCH{1'b0}};
      eie_ff     <= {NCH{1'b0}};
      sign_ff    <= {NCH{1'b0}};
      ien_ff     <= {`ACTS_IRQ_W{1'b0}};
    end
    else
    begin
      lvl_sel_ff <= nxt_lvl;
      eie_ff     <= nxt_eie;
      sign_ff    <= nxt_sign;
      ien_ff     <= nxt_ien;
    end
  end

  // channel state and formatted results
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      eis_ff        <= {NCH{1'b0}};
      trig_d_ff     <= {NCH{1'b0}};
      ist_ff        <= {`ACTS_IRQ_W{1'b0}};
      conv_start_ff <= {NCH{1'b0}};
      ready_ff      <= {NCH{1'b0}};
      fmt_valid_ff  <= 1'b0;
      fmt_chan_ff   <= 5'h00;
      fmt_data_ff   <= 16'h0000;
      irq           <= 1'b0;
    end
    else
    begin
      trig_d_ff     <= chan_trigger;
      conv_start_ff <= nxt_start;
      eis_ff        <= nxt_eis;
      ready_ff      <= nxt_ready;
      ist_ff        <= nxt_ist;
      irq           <= |(ist_ff & ien_ff);
      // signed: offset binary flipped to two's complement and sign extended
      fmt_valid_ff <= result_valid;
      fmt_chan_ff  <= result_chan;
      if (result_valid)
      begin
        if (res_sign)
          fmt_data_ff <= {{(16-RW){~result_raw[RW-1]}},
                          ~result_raw[RW-1], result_raw[RW-2:0]};
        else
          fmt_data_ff <= {{(16-RW){1'b0}}, result_raw};
      end
    end
  end

endmodule

// *** acts_channel_cfg_props.sv ***
// port-level assertions for the channel trigger/sign block
`timescale 1ns/100ps
module acts_cfg_props #(parameter NCH = 21, parameter RW = 12) (
  // clock and reset
  input logic           hclk,
  input logic           hresetn,
  // bus answer
  input logic [31:0]    hrdata,
  input logic           hreadyout,
  input logic           hresp,
  // converter side
  input logic [NCH-1:0] chan_trigger,
  input logic [NCH-1:0] conv_busy,
  input logic           result_valid,
  input logic [4:0]     result_chan,
  input logic [RW-1:0]  result_raw,
  input logic [NCH-1:0] conv_start_ff,
  input logic           fmt_valid_ff,
  input logic [4:0]     fmt_chan_ff,
  input logic [15:0]    fmt_data_ff,
  input logic [NCH-1:0] ready_ff
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_res;
    result_valid && result_chan < NCH;
  endsequence
  property p_fmt;
    s_res |=> fmt_data_ff == {{(16-RW){1'b0}}, $past(result_raw)} ||
      fmt_data_ff == {{(17-RW){~$past(result_raw[RW-1])}}, $past(result_raw[RW-2:0])};
  endproperty
  property p_rdy;
    s_res |=> ready_ff[$past(result_chan)];
  endproperty
  a_fmt_follows: assert property (s_res |=> fmt_valid_ff && fmt_chan_ff == $past(result_chan))
    else $error("formatted result missing or wrong channel");
  a_fmt_no_cause: assert property (fmt_valid_ff |-> $past(result_valid))
    else $error("formatted result without a raw result");
  a_fmt_value: assert property (p_fmt)
    else $error("formatted value is neither signed nor unsigned form");
  a_ready_sets: assert property (p_rdy)
    else $error("ready flag not set after result");
  a_start_busy: assert property ((conv_start_ff & $past(conv_busy)) == '0)
    else $error("start raised on a busy channel");
  a_start_trig: assert property ((conv_start_ff & ~$past(chan_trigger)) == '0)
    else $error("start raised without trigger");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
endmodule
bind acts_channel_cfg acts_cfg_props #(.NCH(NCH), .RW(RW)) acts_cfg_props_i (.hclk, .hresetn,
  .hrdata, .hreadyout, .hresp, .chan_trigger, .conv_busy, .result_valid, .result_chan,
  .result_raw, .conv_start_ff, .fmt_valid_ff, .fmt_chan_ff, .fmt_data_ff, .ready_ff);

// *** acts_channel_cfg_tb.sv ***
// self-checking bench for the channel trigger/sign block
`timescale 1ns/100ps
`include "acts_regs.vh"
module acts_channel_cfg_tb;
  logic        hclk, hresetn, hsel, hwrite, result_valid, buf_read;
  logic        hreadyout, hresp, fmt_valid_ff, irq;
  logic [11:0] haddr, result_raw;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [20:0] chan_trigger, conv_busy, early_event, conv_start_ff, ready_ff;
  logic [4:0]  result_chan, buf_read_chan, fmt_chan_ff;
  logic [15:0] fmt_data_ff;
  int          err_count = 0, tests_run = 0, n0, n1, n16;
  logic [11:0] ofs [7] = '{`ACTS_OFS_LVL_LO, `ACTS_OFS_LVL_HI, `ACTS_OFS_EIE_LO,
    `ACTS_OFS_EIE_HI, `ACTS_OFS_MOD0_LO, `ACTS_OFS_MOD0_HI, `ACTS_OFS_MOD1_LO};
  logic [15:0] msk [7] = '{16'hffff, 16'h001f, 16'hffff, 16'h001f, 16'h5555, 16'h5555,
    16'h0155};
  acts_channel_cfg acts_channel_cfg_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .chan_trigger,
    .conv_busy, .early_event, .result_valid, .result_chan, .result_raw, .buf_read,
    .buf_read_chan, .conv_start_ff, .fmt_valid_ff, .fmt_chan_ff, .fmt_data_ff, .ready_ff,
    .irq);
  initial
  begin
    hclk = 0;
    forever #2 hclk = ~hclk;
  end
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // the master never assumes a latency; a stuck slave ends the run
  task rdy_edge;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      err_count++;
      results;
    end
  endtask
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    rdy_edge;
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    rdy_edge;
    rd = hrdata;
  endtask
  task res(input logic [4:0] c, input logic [11:0] r, input logic [15:0] e);
    result_valid <= 1'b1;
    result_chan <= c;
    result_raw <= r;
    @(posedge hclk);
    result_valid <= 1'b0;
    @(posedge hclk);
    chk("format", {fmt_valid_ff, 10'h000, fmt_chan_ff, fmt_data_ff}, {1'b1, 10'h000, c, e});
    chk("ready", ready_ff[c], 1);
  endtask
  initial
  begin
    hresetn = 0;
    {hsel, haddr, htrans, hwrite, hwdata, buf_read, buf_read_chan} = '0;
    hsize = 3'h2;
    {chan_trigger, conv_busy, early_event, result_valid, result_chan, result_raw} = '0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++)
    begin
      ahb(0, ofs[i], 0);
      chk("reset value", rd, 0);
      ahb(1, ofs[i], 32'hffffffff);
      ahb(0, ofs[i], 0);
      chk("masked readback", rd, {16'h0000, msk[i]});
    end
    ahb(1, 12'h0f0, 32'hffffffff);
    ahb(0, 12'h0f0, 0);
    chk("unmapped", rd, 0);
    res(5'd3, 12'h7ff, 16'hffff);
    res(5'd8, 12'h800, 16'h0000);
    res(5'd20, 12'h123, 16'hf923);
    ahb(1, `ACTS_OFS_MOD0_LO, 0);
    res(5'd3, 12'h7ff, 16'h07ff);
    ahb(1, `ACTS_OFS_EIE_HI, 0);
    early_event <= 21'h020004;
    @(posedge hclk);
    early_event <= '0;
    ahb(0, `ACTS_OFS_EIS_LO, 0);
    chk("early flag", rd, 32'h4);
    ahb(0, `ACTS_OFS_EIS_HI, 0);
    chk("early disabled", rd, 0);
    ahb(1, `ACTS_OFS_IRQ_EN, 1);
    repeat (2) @(posedge hclk);
    chk("irq on", irq, 1);
    ahb(0, `ACTS_OFS_IRQ_STAT, 0);
    chk("irq status", rd, 32'h3);
    ahb(1, `ACTS_OFS_IRQ_EN, 0);
    repeat (2) @(posedge hclk);
    chk("irq masked", irq, 0);
    buf_read <= 1'b1;
    buf_read_chan <= 5'd2;
    @(posedge hclk);
    buf_read <= 1'b0;
    ahb(0, `ACTS_OFS_EIS_LO, 0);
    chk("flag cleared", rd, 0);
    ahb(1, `ACTS_OFS_IRQ_CLR, 1);
    ahb(0, `ACTS_OFS_IRQ_STAT, 0);
    chk("status cleared", rd, 32'h2);
    ahb(1, `ACTS_OFS_IRQ_EN, 3);
    ahb(0, `ACTS_OFS_IRQ_EN, 0);
    chk("irq enable", rd, 32'h3);
    ahb(1, `ACTS_OFS_IRQ_EN, 0);
    ahb(0, `ACTS_OFS_RDY_LO, 0);
    chk("ready low", rd, 32'h0108);
    ahb(0, `ACTS_OFS_RDY_HI, 0);
    chk("ready high", rd, 32'h10);
    buf_read <= 1'b1;
    buf_read_chan <= 5'd5;
    early_event <= 21'h000020;
    @(posedge hclk);
    buf_read_chan <= 5'd3;
    early_event <= '0;
    @(posedge hclk);
    buf_read <= 1'b0;
    ahb(0, `ACTS_OFS_EIS_LO, 0);
    chk("set wins", rd, 32'h20);
    ahb(0, `ACTS_OFS_RDY_LO, 0);
    chk("ready cleared", rd, 32'h0100);
    ahb(1, `ACTS_OFS_EIS_LO, 0);
    ahb(0, `ACTS_OFS_EIS_LO, 0);
    chk("flag write clear", rd, 0);
    ahb(1, `ACTS_OFS_LVL_HI, 0);
    chan_trigger <= 21'h010003;
    conv_busy <= 21'h000002;
    {n0, n1, n16} = '0;
    for (int i = 1; i <= 6; i++)
    begin
      @(posedge hclk);
      n0 += (conv_start_ff[0] === 1'b1);
      n1 += (conv_start_ff[1] === 1'b1);
      n16 += (conv_start_ff[16] === 1'b1);
      if (i == 4)
        chan_trigger <= '0;
    end
    conv_busy <= '0;
    chk("level starts", n0, 4);
    chk("busy starts", n1, 0);
    chk("edge starts", n16, 1);
    results;
  end
endmodule

// *** acts_regs.vh ***
// register map, field layout and reset values of the channel trigger/sign block
`ifndef ACTS_REGS_VH
`define ACTS_REGS_VH

`define ACTS_OFS_LVL_LO    12'h000
`define ACTS_OFS_LVL_HI    12'h004
`define ACTS_OFS_EIE_LO    12'h008
`define ACTS_OFS_EIE_HI    12'h00c
`define ACTS_OFS_EIS_LO    12'h010
`define ACTS_OFS_EIS_HI    12'h014
`define ACTS_OFS_MOD0_LO   12'h018
`define ACTS_OFS_MOD0_HI   12'h01c
`define ACTS_OFS_MOD1_LO   12'h020
`define ACTS_OFS_IRQ_STAT  12'h024
`define ACTS_OFS_IRQ_CLR   12'h028
`define ACTS_OFS_IRQ_EN    12'h02c
`define ACTS_OFS_RDY_LO    12'h030
`define ACTS_OFS_RDY_HI    12'h034

`define ACTS_HI_MASK       16'h001f
`define ACTS_MOD_EVEN_MASK 16'h5555
`define ACTS_MOD1_MASK     16'h0155
`define ACTS_RESET_VAL     16'h0000

// interrupt status bits: early irq, result ready
`define ACTS_IRQ_EARLY     0
`define ACTS_IRQ_READY     1
`define ACTS_IRQ_W         2

`endif
